/* File: hw/regulator_control_regs.sv */
// Functional notes
// - undervoltage response: ignore, shutdown, device reset
// - every undervoltage fault sets interrupt status
// - hardware control source selects input 1/2/either
// - hardware control picks active or sleep voltage
// - hardware mode: low power, off, follow
// - float bit stops discharge; switch bit
// - startup slot 1..5 enables, 0 never
// - slot codes 110/111 follow hardware enables
// - active mode bit selects normal or low power
// - codes 00h-0Ch give 1.0-1.6V, 50mV
// - codes 0Dh-1Fh give 1.7-3.5V, 100mV
// - slot and voltage loadable from OTP
// - hw-enabled regulators sleep in selected slot
`default_nettype none

`include "regulator_control_regs_cfg.svh"

module regulator_control_regs
    import regulator_control_regs_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_SRST,
    input wire logic [16:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic [2:0] I_UV_FAULT,
    input wire logic [1:0] I_HW_CTRL,
    input wire logic [1:0] I_HW_EN,
    input wire logic [2:0] I_SEQ_SLOT,
    input wire logic I_SEQ_STEP,
    input wire logic I_SEQ_DOWN,
    input wire logic I_SEQ_SLEEP_STEP,
    input wire logic I_SEQ_WAKE,
    input wire logic I_OTP_LOAD,
    input wire logic [8:0] I_OTP_SLOT,
    input wire logic [14:0] I_OTP_VCODE,
    input wire logic [15:0] I_REG7_SLEEP_CFG,
    output logic [2:0] O_REG_ENABLE,
    output logic [2:0] O_REG_LOW_POWER,
    output logic [14:0] O_REG_VCODE,
    output logic [35:0] O_REG_MV,
    output logic [2:0] O_REG_DISCHARGE,
    output logic [2:0] O_REG_PASS_SWITCH,
    output logic O_DEVICE_RESET,
    output logic O_IRQ
);

    // ======================================================================
    // helpers
    function automatic logic [11:0] code_to_mv(input logic [4:0] c);
        logic [11:0] r;
        r = 12'(`VHIGH_BASE_MV + `VHIGH_STEP_MV * (int'(c) - int'(`VHIGH_FIRST)));
        if (c <= `VLOW_LAST)
        begin
            r = 12'(`VLOW_BASE_MV + `VLOW_STEP_MV * int'(c));
        end
        return r;
    endfunction : code_to_mv

    function automatic logic [15:0] read_word(input state_s st, input logic [14:0] idx);
        logic [15:0] r;
        r = 16'h0000;
        case (idx)
            `IDX_GEN5: r = st.gen[0];
            `IDX_ON5: r = st.on[0];
            `IDX_SLP5: r = st.slp[0];
            `IDX_GEN6: r = st.gen[1];
            `IDX_ON6: r = st.on[1];
            `IDX_SLP6: r = st.slp[1];
            `IDX_GEN7: r = st.gen[2];
            `IDX_ON7: r = st.on[2];
            `IDX_STATUS: r = {13'h0000, st.status};
            `IDX_MASK: r = {13'h0000, st.mask};
            default: r = 16'h0000;
        endcase
        return r;
    endfunction : read_word

    // ======================================================================
    // state
    state_s s_r;
    state_s s_nxt;

    logic [14:0] idx;
    logic take_wr;
    logic [15:0] cur;
    logic [15:0] wv;
    logic [2:0] clr;
    logic [2:0][15:0] slv;

    assign idx = I_AVS_ADDRESS[16:2];
    assign take_wr = (s_r.bus == BUS_ACK) && I_AVS_WRITE;
    assign cur = read_word(s_r, idx);
    assign slv = {I_REG7_SLEEP_CFG, s_r.slp[1], s_r.slp[0]};

    always_comb
    begin
        wv = cur;
        if (I_AVS_BYTEENABLE[0])
        begin
            wv[7:0] = I_AVS_WRITEDATA[7:0];
        end
        if (I_AVS_BYTEENABLE[1])
        begin
            wv[15:8] = I_AVS_WRITEDATA[15:8];
        end
    end

    // status bits cleared by writing one
    assign clr = (take_wr && idx == `IDX_STATUS && I_AVS_BYTEENABLE[0]) ?
        I_AVS_WRITEDATA[2:0] : 3'h0;

    // ======================================================================
    // next state
    always_comb
    begin
        logic [15:0] g;
        logic [15:0] o;
        logic [15:0] sl;
        logic [2:0] slot;
        logic [2:0] sslot;
        logic hwa;
        logic en;
        logic lp;
        logic [4:0] vc;
        s_nxt = s_r;
        s_nxt.dev_rst = 1'b0;
        g = 16'h0000;
        o = 16'h0000;
        sl = 16'h0000;
        slot = 3'h0;
        sslot = 3'h0;
        hwa = 1'b0;
        en = 1'b0;
        lp = 1'b0;
        vc = 5'h00;

        // bus handshake: read data captured entering the answer cycle
        case (s_r.bus)
            BUS_IDLE:
            begin
                if (I_AVS_READ || I_AVS_WRITE)
                begin
                    s_nxt.bus = BUS_ACK;
                end
                if (I_AVS_READ)
                begin
                    s_nxt.rdata = {16'h0000, cur};
                end
            end
            BUS_ACK: s_nxt.bus = BUS_IDLE;
            default: s_nxt.bus = BUS_IDLE;
        endcase

        // one-time memory preload of slot and voltage
        if (I_OTP_LOAD)
        begin
            for (int i = 0; i < 3; i++)
            begin
                s_nxt.on[i][`SLOT_HI:`SLOT_LO] = I_OTP_SLOT[3*i +: 3];
                s_nxt.on[i][`VC_HI:`VC_LO] = I_OTP_VCODE[5*i +: 5];
            end
        end

        // register writes
        if (take_wr)
        begin
            case (idx)
                `IDX_GEN5: s_nxt.gen[0] = wv & `GEN_WMASK;
                `IDX_ON5: s_nxt.on[0] = wv & `ONSLP_WMASK;
                `IDX_SLP5: s_nxt.slp[0] = wv & `ONSLP_WMASK;
                `IDX_GEN6: s_nxt.gen[1] = wv & `GEN_WMASK;
                `IDX_ON6: s_nxt.on[1] = wv & `ONSLP_WMASK;
                `IDX_SLP6: s_nxt.slp[1] = wv & `ONSLP_WMASK;
                `IDX_GEN7: s_nxt.gen[2] = wv & `GEN_WMASK;
                `IDX_ON7: s_nxt.on[2] = wv & `ONSLP_WMASK;
                `IDX_MASK: s_nxt.mask = wv[2:0];
                default: s_nxt.mask = s_nxt.mask;
            endcase
        end

        // fault capture: the set wins over a same-cycle clear
        s_nxt.status = (s_r.status & ~clr) | I_UV_FAULT;
        s_nxt.shut = s_r.shut & ~(clr & ~I_UV_FAULT);

        for (int i = 0; i < 3; i++)
        begin
            g = s_r.gen[i];
            o = s_r.on[i];
            sl = slv[i];
            slot = o[`SLOT_HI:`SLOT_LO];
            sslot = sl[`SLOT_HI:`SLOT_LO];

            if (I_UV_FAULT[i])
            begin
                case (uv_resp_e'(g[`UVR_HI:`UVR_LO]))
                    UV_SHUTDOWN: s_nxt.shut[i] = 1'b1;
                    UV_DEV_RESET: s_nxt.dev_rst = 1'b1;
                    default: s_nxt.shut[i] = s_nxt.shut[i];
                endcase
            end

            // power-up sequencer timeslots
            if (I_SEQ_DOWN)
            begin
                s_nxt.seq_on[i] = 1'b0;
            end
            else if (I_SEQ_STEP && slot != 3'h0 && slot <= `LAST_SLOT && slot == I_SEQ_SLOT)
            begin
                s_nxt.seq_on[i] = 1'b1;
            end

            // sleep entry for hardware-enabled regulators
            if (I_SEQ_WAKE)
            begin
                s_nxt.sleep[i] = 1'b0;
            end
            else if (slot[2:1] == 2'b11 && I_SEQ_SLEEP_STEP && sslot != 3'h0 &&
                sslot <= `LAST_SLOT && sslot == I_SEQ_SLOT)
            begin
                s_nxt.sleep[i] = 1'b1;
            end

            case (hw_src_e'(g[`HWS_HI:`HWS_LO]))
                HWS_IN1: hwa = I_HW_CTRL[0];
                HWS_IN2: hwa = I_HW_CTRL[1];
                HWS_EITHER: hwa = |I_HW_CTRL;
                default: hwa = 1'b0;
            endcase

            case (slot)
                3'h0: en = 1'b0;
                3'h6: en = I_HW_EN[0];
                3'h7: en = I_HW_EN[1];
                default: en = s_r.seq_on[i];
            endcase
            en = en & ~s_r.shut[i];

            vc = o[`VC_HI:`VC_LO];
            lp = o[`MODE_BIT];
            if (s_r.sleep[i])
            begin
                vc = sl[`VC_HI:`VC_LO];
                lp = sl[`MODE_BIT];
            end

            if (hwa)
            begin
                vc = g[`HWV_BIT] ? sl[`VC_HI:`VC_LO] : o[`VC_HI:`VC_LO];
                case (hw_mode_e'(g[`HWM_HI:`HWM_LO]))
                    HWM_OFF: en = 1'b0;
                    HWM_FOLLOW: lp = o[`MODE_BIT];
                    default: lp = 1'b1;
                endcase
            end

            s_nxt.en[i] = en;
            s_nxt.lp[i] = lp;
            s_nxt.vcode[5*i +: 5] = vc;
            s_nxt.mv[12*i +: 12] = code_to_mv(vc);
            s_nxt.disc[i] = ~en & ~g[`FLT_BIT];
            s_nxt.sw[i] = g[`SWI_BIT];
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            s_r <= '0;
            s_r.bus <= BUS_IDLE;
            s_r.gen[0] <= `GEN56_RESET;
            s_r.gen[1] <= `GEN56_RESET;
            s_r.gen[2] <= `GEN7_RESET;
            s_r.on <= {3{`ONSLP_RESET}};
            s_r.slp <= {2{`ONSLP_RESET}};
            s_r.mv <= {3{12'(`VLOW_BASE_MV)}};
            s_r.disc <= 3'h7;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // outputs
    assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && s_r.bus != BUS_ACK;
    assign O_AVS_READDATA = s_r.rdata;
    assign O_REG_ENABLE = s_r.en;
    assign O_REG_LOW_POWER = s_r.lp;
    assign O_REG_VCODE = s_r.vcode;
    assign O_REG_MV = s_r.mv;
    assign O_REG_DISCHARGE = s_r.disc;
    assign O_REG_PASS_SWITCH = s_r.sw;
    assign O_DEVICE_RESET = s_r.dev_rst;
    assign O_IRQ = |(s_r.status & s_r.mask);

endmodule : regulator_control_regs

`default_nettype wire

/* File: hw/regulator_control_regs_cfg.svh */
`ifndef REGULATOR_CONTROL_REGS_CFG_SVH
`define REGULATOR_CONTROL_REGS_CFG_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define IDX_GEN5 15'h4074
`define IDX_ON5 15'h4075
`define IDX_SLP5 15'h4076
`define IDX_GEN6 15'h4077
`define IDX_ON6 15'h4078
`define IDX_SLP6 15'h4079
`define IDX_GEN7 15'h407A
`define IDX_ON7 15'h407B
`define IDX_STATUS 15'h4090
`define IDX_MASK 15'h4091

// ==========================================================================
// writable bits and reset values
`define GEN_WMASK 16'hDFC1
`define ONSLP_WMASK 16'hE11F
`define GEN56_RESET 16'h0200
`define GEN7_RESET 16'h0000
`define ONSLP_RESET 16'h0000

// ==========================================================================
// field positions
`define UVR_HI 15
`define UVR_LO 14
`define HWS_HI 12
`define HWS_LO 11
`define HWV_BIT 10
`define HWM_HI 9
`define HWM_LO 8
`define FLT_BIT 7
`define SWI_BIT 6
`define SLOT_HI 15
`define SLOT_LO 13
`define MODE_BIT 8
`define VC_HI 4
`define VC_LO 0

// ==========================================================================
// voltage code mapping
`define VLOW_LAST 5'h0C
`define VLOW_BASE_MV 1000
`define VLOW_STEP_MV 50
`define VHIGH_FIRST 5'h0D
`define VHIGH_BASE_MV 1700
`define VHIGH_STEP_MV 100
`define LAST_SLOT 3'h5

`endif

/* File: hw/regulator_control_regs_pkg.sv */
`default_nettype none

package regulator_control_regs_pkg;

    // ======================================================================
    // encodings
    typedef enum logic [1:0] {
        UV_IGNORE = 2'h0,
        UV_SHUTDOWN = 2'h1,
        UV_DEV_RESET = 2'h2,
        UV_RESERVED = 2'h3
    } uv_resp_e;

    typedef enum logic [1:0] {
        HWS_OFF = 2'h0,
        HWS_IN1 = 2'h1,
        HWS_IN2 = 2'h2,
        HWS_EITHER = 2'h3
    } hw_src_e;

    typedef enum logic [1:0] {
        HWM_LP_A = 2'h0,
        HWM_OFF = 2'h1,
        HWM_LP_B = 2'h2,
        HWM_FOLLOW = 2'h3
    } hw_mode_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_e;

    // ======================================================================
    // whole state of the register bank
    typedef struct packed {
        bus_state_e bus;
        logic [31:0] rdata;
        logic [2:0][15:0] gen;
        logic [2:0][15:0] on;
        logic [1:0][15:0] slp;
        logic [2:0] status;
        logic [2:0] mask;
        logic [2:0] seq_on;
        logic [2:0] sleep;
        logic [2:0] shut;
        logic dev_rst;
        logic [2:0] en;
        logic [2:0] lp;
        logic [14:0] vcode;
        logic [35:0] mv;
        logic [2:0] disc;
        logic [2:0] sw;
    } state_s;

endpackage : regulator_control_regs_pkg

`default_nettype wire

/* File: verification/regulator_control_regs_checker.sv */
`default_nettype none

module regulator_control_regs_checker (
    input wire logic I_MCLK,
    input wire logic I_SRST,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic [2:0] I_UV_FAULT,
    input wire logic O_DEVICE_RESET,
    input wire logic O_IRQ,
    input wire logic [2:0] O_REG_ENABLE,
    input wire logic [2:0] O_REG_DISCHARGE,
    input wire logic [14:0] O_REG_VCODE,
    input wire logic [35:0] O_REG_MV
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_SRST);

    function automatic logic mv_ok(logic [14:0] v, logic [35:0] m, logic hi);
        logic ok = 1'b1;
        int c;
        for (int i = 0; i < 3; i++)
        begin
            c = v[5 * i +: 5];
            if ((c > 12) == hi)
                ok &= m[12 * i +: 12] == 12'(hi ? 1700 + 100 * (c - 13) : 1000 + 50 * c);
        end
        return ok;
    endfunction : mv_ok

    // ==========================================================================
    // properties
    a_wait_one: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST
        |=> !O_AVS_WAITREQUEST) else $error("wait longer than one cycle");
    a_mv_low: assert property (mv_ok(O_REG_VCODE, O_REG_MV, 1'b0))
        else $error("low code voltage wrong");
    a_mv_high: assert property (mv_ok(O_REG_VCODE, O_REG_MV, 1'b1))
        else $error("high code voltage wrong");
    a_disc_off: assert property ((O_REG_DISCHARGE & O_REG_ENABLE) == 3'h0)
        else $error("discharge while enabled");
    a_rst_cause: assert property (O_DEVICE_RESET |-> $past(I_UV_FAULT) != 3'h0)
        else $error("device reset without fault");
    a_rst_pulse: assert property (O_DEVICE_RESET |=> !O_DEVICE_RESET)
        else $error("device reset longer than one cycle");
    a_irq_cause: assert property ($rose(O_IRQ) |-> $past(I_UV_FAULT) != 3'h0
        || $past(I_AVS_WRITE)) else $error("interrupt without cause");
    a_reset_vals: assert property (disable iff (1'b0) I_SRST |=> O_REG_MV == 36'h3E83E83E8
        && O_REG_DISCHARGE == 3'h7 && O_REG_ENABLE == 3'h0 && !O_IRQ)
        else $error("reset values wrong");
    c_dev_rst: cover property (O_DEVICE_RESET);
    c_irq: cover property ($rose(O_IRQ));
    c_top_code: cover property (O_REG_VCODE[4:0] == 5'h1F);
endmodule : regulator_control_regs_checker

bind regulator_control_regs regulator_control_regs_checker i_chk (.*);

`default_nettype wire

/* File: verification/regulator_control_regs_tb.sv */
`default_nettype none
`include "regulator_control_regs_cfg.svh"
`define CK(n, e, s) ck(n, 36'(e), 36'(s));

module regulator_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic I_MCLK = 0, I_SRST = 1, I_AVS_READ = 0, I_AVS_WRITE = 0, O_AVS_WAITREQUEST;
    logic I_SEQ_STEP = 0, I_SEQ_DOWN = 0, I_SEQ_SLEEP_STEP = 0, I_SEQ_WAKE = 0;
    logic I_OTP_LOAD = 0, O_DEVICE_RESET, O_IRQ, act;
    logic [16:0] I_AVS_ADDRESS = 0;
    logic [31:0] I_AVS_WRITEDATA = 0, O_AVS_READDATA;
    logic [3:0] I_AVS_BYTEENABLE = 4'hF;
    logic [2:0] I_UV_FAULT = 0, I_SEQ_SLOT = 0, O_REG_ENABLE, O_REG_LOW_POWER;
    logic [2:0] O_REG_DISCHARGE, O_REG_PASS_SWITCH;
    logic [1:0] I_HW_CTRL = 0, I_HW_EN = 0, src;
    logic [8:0] I_OTP_SLOT = 0;
    logic [14:0] I_OTP_VCODE = 0, O_REG_VCODE;
    logic [15:0] I_REG7_SLEEP_CFG = 0, rv, d;
    logic [35:0] O_REG_MV;
    int err_total = 0, n_compared = 0, seed = 5543, k, f;

    regulator_control_regs i_dut (.*);

    task automatic ck(string n, logic [35:0] e, logic [35:0] s);
        n_compared++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %0h got %0h", n, e, s);
        end
    endtask : ck

    task automatic give_verdict;
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // ==========================================================================
    // bus and fault drivers
    task automatic bus(logic w, logic [14:0] a, logic [15:0] v);
        int t = 0;
        I_AVS_ADDRESS <= {a, 2'h0};
        I_AVS_WRITEDATA <= {16'($random(seed)), v};
        I_AVS_BYTEENABLE <= 4'($random(seed)) | 4'h3;
        I_AVS_WRITE <= w;
        I_AVS_READ <= !w;
        do
        begin
            @(negedge I_MCLK);
            t++;
        end
        while (O_AVS_WAITREQUEST !== 1'b0 && t < 20);
        if (t >= 20)
        begin
            err_total++;
            give_verdict();
        end
        @(posedge I_MCLK);
        rv = O_AVS_READDATA[15:0];
        I_AVS_WRITE <= 0;
        I_AVS_READ <= 0;
        @(posedge I_MCLK);
    endtask : bus

    task automatic rd(logic [14:0] a, logic [15:0] e);
        bus(0, a, 16'h0000);
        `CK("readback", e, rv)
    endtask : rd

    task automatic nx(int n);
        repeat (n) @(posedge I_MCLK);
        @(negedge I_MCLK);
    endtask : nx

    task automatic pulse_uv(logic [2:0] u);
        I_UV_FAULT <= u;
        @(posedge I_MCLK);
        I_UV_FAULT <= 3'h0;
        f = 0;
        repeat (4)
        begin
            @(negedge I_MCLK);
            f += O_DEVICE_RESET;
        end
    endtask : pulse_uv

    initial
    begin
        forever #4 I_MCLK = ~I_MCLK;
    end

    initial
    begin
        repeat (100000) @(posedge I_MCLK);
        err_total++;
        give_verdict();
    end

    initial
    begin
        repeat (20) @(posedge I_MCLK);
        I_SRST <= 0;
        @(posedge I_MCLK);
        for (k = 0; k < 9; k++)
            rd(15'h4074 + 15'(k), (k % 3 == 0 && k < 4) ? 16'h0200 : 16'h0000);
        for (k = 0; k < 27; k++)
        begin
            d = 16'($random(seed));
            bus(1, 15'h4074 + 15'(k % 9), d);
            rd(15'h4074 + 15'(k % 9), k % 9 == 8 ? 16'h0000 :
                d & (k % 3 == 0 ? `GEN_WMASK : `ONSLP_WMASK));
            bus(1, 15'h4074 + 15'(k % 9), 16'h0000);
        end
        bus(1, `IDX_ON6, 16'hA000);
        bus(1, `IDX_GEN6, 16'h00C0);
        bus(1, `IDX_ON5, 16'h2000);
        for (k = 1; k < 6; k++)
        begin
            I_SEQ_SLOT <= 3'(k);
            I_SEQ_STEP <= 1;
            @(posedge I_MCLK);
            I_SEQ_STEP <= 0;
            nx(1);
            `CK("enable", {1'b0, k == 5, 1'b1}, O_REG_ENABLE)
            `CK("discharge", 3'h4, O_REG_DISCHARGE)
            `CK("switch", 3'h2, O_REG_PASS_SWITCH)
            @(posedge I_MCLK);
        end
        for (k = 0; k < 32; k++)
        begin
            bus(1, `IDX_ON5, 16'h2000 | 16'(k) | 16'(k % 2) << 8);
            nx(0);
            `CK("vcode", k, O_REG_VCODE[4:0])
            `CK("mv", k <= 12 ? 1000 + 50 * k : 1700 + 100 * (k - 13), O_REG_MV[11:0])
            `CK("lowpower", k % 2, O_REG_LOW_POWER[0])
            @(posedge I_MCLK);
        end
        for (k = 0; k < 8; k++)
        begin
            bus(1, `IDX_ON7, k < 4 ? 16'hC000 : 16'hE000);
            I_HW_EN <= 2'(k);
            nx(2);
            `CK("hw_enable", k < 4 ? k[0] : k[1], O_REG_ENABLE[2])
            @(posedge I_MCLK);
        end
        bus(1, `IDX_SLP5, 16'h0013);
        bus(1, `IDX_ON5, 16'h201F);
        for (k = 0; k < 64; k++)
        begin
            src = 2'(k >> 2);
            f = $random(seed) & 1;
            bus(1, `IDX_GEN5, {3'h0, src, 1'(f), 2'(k >> 4), 8'h00});
            I_HW_CTRL <= 2'(k);
            nx(2);
            act = |(src & 2'(k));
            `CK("hwc_enable", !(act && k >> 4 == 1), O_REG_ENABLE[0])
            if (!(act && k >> 4 == 1))
            begin
                `CK("hwc_lowpower", act && k >> 4 != 3, O_REG_LOW_POWER[0])
                `CK("hwc_vcode", act && f ? 5'h13 : 5'h1F, O_REG_VCODE[4:0])
            end
            @(posedge I_MCLK);
        end
        bus(1, `IDX_MASK, 16'h0007);
        bus(1, `IDX_GEN5, 16'h4000);
        bus(1, `IDX_GEN6, 16'h8000);
        bus(1, `IDX_GEN7, 16'hC000);
        for (k = 0; k < 3; k++)
        begin
            pulse_uv(3'(1 << k));
            if (k != 1)
                `CK("uv_enable", k != 0, O_REG_ENABLE[k])
            `CK("uv_dev_reset", k == 1, f)
            `CK("uv_irq", 1, O_IRQ)
            @(posedge I_MCLK);
            rd(`IDX_STATUS, 16'(1 << k));
            bus(1, `IDX_STATUS, 16'(1 << k));
            nx(1);
            `CK("irq_clear", 0, O_IRQ)
            @(posedge I_MCLK);
        end
        bus(1, `IDX_MASK, 16'h0003);
        pulse_uv(3'h4);
        `CK("irq_masked", 0, O_IRQ)
        @(posedge I_MCLK);
        rd(`IDX_STATUS, 16'h0004);
        I_REG7_SLEEP_CFG <= 16'h6115;
        I_SEQ_SLOT <= 3'h3;
        I_SEQ_SLEEP_STEP <= 1;
        @(posedge I_MCLK);
        I_SEQ_SLEEP_STEP <= 0;
        nx(1);
        `CK("sleep_vcode", 5'h15, O_REG_VCODE[14:10])
        `CK("sleep_lowpower", 1, O_REG_LOW_POWER[2])
        @(posedge I_MCLK);
        I_SEQ_WAKE <= 1;
        I_SEQ_DOWN <= 1;
        @(posedge I_MCLK);
        I_SEQ_WAKE <= 0;
        I_SEQ_DOWN <= 0;
        nx(1);
        `CK("wake_vcode", 0, O_REG_VCODE[14:10])
        `CK("seq_down", 0, O_REG_ENABLE[0])
        @(posedge I_MCLK);
        I_OTP_SLOT <= 9'($random(seed));
        I_OTP_VCODE <= 15'($random(seed));
        I_OTP_LOAD <= 1;
        @(posedge I_MCLK);
        I_OTP_LOAD <= 0;
        @(posedge I_MCLK);
        for (k = 0; k < 3; k++)
        begin
            bus(0, `IDX_ON5 + 15'(3 * k), 16'h0000);
            `CK("otp", {I_OTP_SLOT[3*k+:3], I_OTP_VCODE[5*k+:5]}, {rv[15:13], rv[4:0]})
        end
        give_verdict();
    end
endmodule : regulator_control_regs_tb

`default_nettype wire
